// *** inc/swnvm_pkg.sv ***
// Notes on behaviour
// - Fifty words of fourteen bits, each alterable.
// - Three mode lines select one of seven operations.
// - Standby keeps registers, data pin undriven.
// - Erase clears the addressed word to low.
// - Address entry shifts pin bits into address.
// - Address is one-of-five plus one-of-ten digits.
// - Read copies addressed word into data register.
// - Shift-out drives data register onto the pin.
// - Write ORs data register into addressed word.
// - Data entry shifts pin bits into data register.
// - Pin input in entry, output in shift-out.
// - Host clock 10 to 17 kHz, nominal 14.
// - Host holds erase or write 16 to 24 ms.
// - Host changes lines only while clock high.
// - Output bit within 20 us of change or rise.
package swnvm_pkg;
    localparam int WORD_W         = 14;
    localparam int WORD_COUNT     = 50;
    localparam int TENS_N         = 5;
    localparam int UNITS_N        = 10;
    localparam int ADDR_BITS      = TENS_N + UNITS_N;
    localparam int IDX_W          = 6;

    localparam int CLK_PERIOD_NS  = 25;
    localparam int CLK_FREQ_HZ    = 40_000_000;
    localparam int LINK_FREQ_HZ   = 14_000;
    localparam int LINK_HALF_CYC  = CLK_FREQ_HZ / (2 * LINK_FREQ_HZ);

    localparam int PROG_NOM_US    = 20_000;
    localparam int PROG_PERIODS   = PROG_NOM_US * (LINK_FREQ_HZ / 1_000) / 1_000;
    localparam int PROG_MIN_US    = 16_000;
    localparam int PROG_MIN_CYC   = (PROG_MIN_US * 1_000) / CLK_PERIOD_NS;

    localparam int ACCESS_TIME_NS = 20_000;
    localparam int ACCESS_CYC     = ACCESS_TIME_NS / CLK_PERIOD_NS;
    localparam int OUT_LATENCY    = 2;

    // Mode codes as {mode_select_a, mode_select_b, mode_select_c}
    localparam logic [2:0] MODE_STANDBY  = 3'h7;
    localparam logic [2:0] MODE_RESERVED = 3'h6;
    localparam logic [2:0] MODE_ERASE    = 3'h5;
    localparam logic [2:0] MODE_ADDR     = 3'h4;
    localparam logic [2:0] MODE_READ     = 3'h3;
    localparam logic [2:0] MODE_SHIFT    = 3'h2;
    localparam logic [2:0] MODE_WRITE    = 3'h1;
    localparam logic [2:0] MODE_DATA     = 3'h0;
endpackage : swnvm_pkg

// *** inc/swnvm_if.sv ***
`timescale 1ns/1ps
interface swnvm_if;
    logic link_clk;
    logic mode_select_a;
    logic mode_select_b;
    logic mode_select_c;
    logic host_data;
    logic host_oe;
    logic dev_data;
    logic dev_oe;
    logic data_line;

    // Resolved serial pin; an undriven pin reads low here
    assign data_line = dev_oe ? dev_data : (host_oe ? host_data : 1'b0);

    modport device (
        input  link_clk, mode_select_a, mode_select_b, mode_select_c, data_line,
        output dev_data, dev_oe
    );
    modport host (
        input  data_line,
        output link_clk, mode_select_a, mode_select_b, mode_select_c, host_data, host_oe
    );
endinterface : swnvm_if

// *** hw/swnvm_device.sv ***
`timescale 1ns/1ps
module swnvm_device #(
    parameter int WORD_W       = swnvm_pkg::WORD_W,
    parameter int PROG_MIN_CYC = swnvm_pkg::PROG_MIN_CYC
) (
    input  wire logic                       i_clock,       // System clock
    input  wire logic                       i_reset_n,     // Async reset
    input  wire logic                       i_clock_en,    // Freezes state when low
    swnvm_if.device                         link,          // Serial link
    output logic      [WORD_W-1:0]          o_data_word,   // Data register copy
    output logic      [swnvm_pkg::IDX_W-1:0] o_word_index, // Decoded word
    output logic                            o_index_valid, // Address well formed
    output logic      [2:0]                 o_mode,        // Mode sampled at last fall
    output logic                            o_prog_done    // Erase/write committed pulse
);
    localparam int CNT_W = $clog2(PROG_MIN_CYC + 1);

    generate
        if (WORD_W < 2 || WORD_W > 32) begin : g_bad_width
            $error("swnvm_device: WORD_W out of range");
        end
        if (PROG_MIN_CYC < 1) begin : g_bad_prog
            $error("swnvm_device: PROG_MIN_CYC must be positive");
        end
        if (swnvm_pkg::ACCESS_CYC < swnvm_pkg::OUT_LATENCY) begin : g_bad_access
            $error("swnvm_device: output path slower than access time");
        end
    endgenerate

    logic [WORD_W-1:0]              mem [swnvm_pkg::WORD_COUNT];
    logic [WORD_W-1:0]              data_reg;
    logic [WORD_W-1:0]              next_data_reg;
    logic [swnvm_pkg::ADDR_BITS-1:0] addr_reg;
    logic [swnvm_pkg::ADDR_BITS-1:0] next_addr_reg;
    logic                           clk_prev;
    logic                           link_rise;
    logic                           link_fall;
    logic [2:0]                     mode_now;
    logic [2:0]                     next_mode;
    logic [CNT_W-1:0]               prog_cnt;
    logic [CNT_W-1:0]               next_prog_cnt;
    logic                           prog_armed;
    logic                           next_prog_armed;
    logic                           mem_we;
    logic [WORD_W-1:0]              mem_wdata;
    logic [swnvm_pkg::IDX_W-1:0]    idx;
    logic                           idx_valid;
    logic                           next_dev_data;
    logic                           next_dev_oe;

    assign mode_now  = {link.mode_select_a, link.mode_select_b, link.mode_select_c};
    assign link_rise = link.link_clk & ~clk_prev;
    assign link_fall = ~link.link_clk & clk_prev;

    // One-of-five tens digit over one-of-ten units digit
    always_comb begin
        logic [3:0] tens_hits;
        logic [3:0] unit_hits;
        logic [2:0] tens_pos;
        logic [3:0] unit_pos;
        tens_hits = 4'h0;
        unit_hits = 4'h0;
        tens_pos  = 3'h0;
        unit_pos  = 4'h0;
        for (int t = 0; t < swnvm_pkg::TENS_N; t++) begin
            if (addr_reg[swnvm_pkg::UNITS_N + t]) begin
                tens_hits = tens_hits + 4'h1;
                tens_pos  = 3'(t);
            end
        end
        for (int u = 0; u < swnvm_pkg::UNITS_N; u++) begin
            if (addr_reg[u]) begin
                unit_hits = unit_hits + 4'h1;
                unit_pos  = 4'(u);
            end
        end
        idx_valid = (tens_hits == 4'h1) && (unit_hits == 4'h1);
        idx       = 6'(tens_pos) * 6'hA + 6'(unit_pos);
    end

    always_comb begin
        next_data_reg   = data_reg;
        next_addr_reg   = addr_reg;
        next_mode       = o_mode;
        next_prog_cnt   = prog_cnt;
        next_prog_armed = prog_armed;
        mem_we          = 1'b0;
        mem_wdata       = '0;
        if (link_fall) begin
            next_mode = mode_now;
            case (mode_now)
                swnvm_pkg::MODE_ADDR: begin
                    next_addr_reg = {addr_reg[swnvm_pkg::ADDR_BITS-2:0], link.data_line};
                end
                swnvm_pkg::MODE_DATA: begin
                    next_data_reg = {data_reg[WORD_W-2:0], link.data_line};
                end
                swnvm_pkg::MODE_READ: begin
                    if (idx_valid) begin
                        next_data_reg = mem[idx];
                    end
                end
                default: begin
                    // Standby, reserved, erase, write, shift out: registers hold
                end
            endcase
        end
        // First bit stands at the mode change; later rises shift
        if (link_rise && mode_now == swnvm_pkg::MODE_SHIFT
                && o_mode == swnvm_pkg::MODE_SHIFT) begin
            next_data_reg = {data_reg[WORD_W-2:0], 1'b0};
        end
        // Erase and write commit once the code has been held long enough
        if ((mode_now == swnvm_pkg::MODE_ERASE || mode_now == swnvm_pkg::MODE_WRITE)
                && idx_valid) begin
            if (prog_cnt != CNT_W'(PROG_MIN_CYC)) begin
                next_prog_cnt = prog_cnt + CNT_W'(1);
            end else if (prog_armed) begin
                next_prog_armed = 1'b0;
                mem_we          = 1'b1;
                if (mode_now == swnvm_pkg::MODE_ERASE) begin
                    mem_wdata = '0;
                end else begin
                    mem_wdata = mem[idx] | data_reg;
                end
            end
        end else begin
            next_prog_cnt   = '0;
            next_prog_armed = 1'b1;
        end
    end

    always_comb begin
        next_dev_oe   = (mode_now == swnvm_pkg::MODE_SHIFT);
        next_dev_data = next_dev_oe ? next_data_reg[WORD_W-1] : 1'b0;
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_prev      <= 1'b0;
            data_reg      <= '0;
            addr_reg      <= '0;
            prog_cnt      <= '0;
            prog_armed    <= 1'b1;
            o_mode        <= swnvm_pkg::MODE_STANDBY;
            link.dev_oe   <= 1'b0;
            link.dev_data <= 1'b0;
            o_data_word   <= '0;
            o_word_index  <= '0;
            o_index_valid <= 1'b0;
            o_prog_done   <= 1'b0;
        end else if (i_clock_en) begin
            clk_prev      <= link.link_clk;
            data_reg      <= next_data_reg;
            addr_reg      <= next_addr_reg;
            prog_cnt      <= next_prog_cnt;
            prog_armed    <= next_prog_armed;
            o_mode        <= next_mode;
            link.dev_oe   <= next_dev_oe;
            link.dev_data <= next_dev_data;
            o_data_word   <= next_data_reg;
            o_word_index  <= idx;
            o_index_valid <= idx_valid;
            o_prog_done   <= mem_we;
        end
    end

    // Nonvolatile array: never cleared by reset
    always_ff @(posedge i_clock) begin
        if (i_clock_en && mem_we) begin
            mem[idx] <= mem_wdata;
        end
    end
endmodule : swnvm_device

// *** hw/swnvm_host.sv ***
`timescale 1ns/1ps
module swnvm_host #(
    parameter int WORD_W        = swnvm_pkg::WORD_W,
    parameter int LINK_HALF_CYC = swnvm_pkg::LINK_HALF_CYC,
    parameter int PROG_PERIODS  = swnvm_pkg::PROG_PERIODS
) (
    input  wire logic                        i_clock,      // System clock
    input  wire logic                        i_reset_n,    // Async reset
    input  wire logic                        i_clock_en,   // Freezes state when low
    swnvm_if.host                            link,         // Serial link
    input  wire logic                        i_req_valid,  // Request present
    input  wire logic                        i_req_write,  // 1 write, 0 read
    input  wire logic [swnvm_pkg::IDX_W-1:0] i_req_word,   // Word 0..49
    input  wire logic [WORD_W-1:0]           i_req_data,   // Write data
    output logic                             o_req_ready,  // Idle, may take request
    output logic                             o_resp_valid, // Read data pulse
    output logic      [WORD_W-1:0]           o_resp_data   // Read data
);
    localparam int DIV_W = $clog2(LINK_HALF_CYC + 1);
    localparam int CNT_W = $clog2(PROG_PERIODS + swnvm_pkg::ADDR_BITS + 1);
    localparam int SR_W  = swnvm_pkg::ADDR_BITS;

    generate
        if (WORD_W < 2 || WORD_W > SR_W) begin : g_bad_width
            $error("swnvm_host: WORD_W out of range");
        end
        if (LINK_HALF_CYC < 2 || PROG_PERIODS < 1) begin : g_bad_timing
            $error("swnvm_host: timing parameters too small");
        end
    endgenerate

    typedef enum logic [6:0] {
        H_IDLE  = 7'h01,
        H_ADDR  = 7'h02,
        H_ERASE = 7'h04,
        H_DATA  = 7'h08,
        H_WRITE = 7'h10,
        H_READ  = 7'h20,
        H_SHIFT = 7'h40
    } swnvm_state_e;

    swnvm_state_e      state, next_state;
    logic [DIV_W-1:0]  div_cnt, next_div_cnt;
    logic              lclk, next_lclk;
    logic [2:0]        mode, next_mode;
    logic [SR_W-1:0]   sr, next_sr;
    logic [CNT_W-1:0]  cnt, next_cnt;
    logic              op_write, next_op_write;
    logic [WORD_W-1:0] wdata, next_wdata;
    logic [WORD_W-1:0] rdata, next_rdata;
    logic              ready, next_ready;
    logic              resp, next_resp;
    logic              hoe, next_hoe;
    logic              hdat, next_hdat;
    logic              edge_now;
    logic              rise_evt;
    logic              fall_evt;
    logic [2:0]        tens;
    logic [3:0]        units;

    assign edge_now = (div_cnt == DIV_W'(LINK_HALF_CYC - 1));
    assign rise_evt = edge_now & ~lclk;
    assign fall_evt = edge_now & lclk;
    assign tens     = 3'(i_req_word / 6'hA);
    assign units    = 4'(i_req_word % 6'hA);

    always_comb begin
        next_div_cnt  = edge_now ? '0 : div_cnt + DIV_W'(1);
        next_lclk     = edge_now ? ~lclk : lclk;
        next_state    = state;
        next_mode     = mode;
        next_sr       = sr;
        next_cnt      = cnt;
        next_op_write = op_write;
        next_wdata    = wdata;
        next_rdata    = rdata;
        next_ready    = ready;
        next_resp     = 1'b0;
        next_hoe      = hoe;
        next_hdat     = hdat;
        if (state == H_IDLE && ready && i_req_valid && i_req_word < 6'(swnvm_pkg::WORD_COUNT)) begin
            next_ready    = 1'b0;
            next_op_write = i_req_write;
            next_wdata    = i_req_data;
            next_sr       = {5'(5'h01 << tens), 10'(10'h001 << units)};
        end
        if (fall_evt && state == H_SHIFT) begin
            next_rdata = {rdata[WORD_W-2:0], link.data_line};
        end
        // Lines change only on the rising link edge
        if (rise_evt) begin
            case (state)
                H_IDLE: begin
                    if (!ready) begin
                        next_state = H_ADDR;
                        next_mode  = swnvm_pkg::MODE_ADDR;
                        next_hoe   = 1'b1;
                        next_hdat  = sr[SR_W-1];
                        next_sr    = {sr[SR_W-2:0], 1'b0};
                        next_cnt   = CNT_W'(SR_W - 1);
                    end
                end
                H_ADDR: begin
                    if (cnt != '0) begin
                        next_hdat = sr[SR_W-1];
                        next_sr   = {sr[SR_W-2:0], 1'b0};
                        next_cnt  = cnt - CNT_W'(1);
                    end else if (op_write) begin
                        next_state = H_ERASE;
                        next_mode  = swnvm_pkg::MODE_ERASE;
                        next_hoe   = 1'b0;
                        next_cnt   = CNT_W'(PROG_PERIODS - 1);
                    end else begin
                        next_state = H_READ;
                        next_mode  = swnvm_pkg::MODE_READ;
                        next_hoe   = 1'b0;
                    end
                end
                H_ERASE: begin
                    if (cnt != '0) begin
                        next_cnt = cnt - CNT_W'(1);
                    end else begin
                        next_state = H_DATA;
                        next_mode  = swnvm_pkg::MODE_DATA;
                        next_hoe   = 1'b1;
                        next_hdat  = wdata[WORD_W-1];
                        next_sr    = SR_W'({wdata[WORD_W-2:0], 1'b0}) << (SR_W - WORD_W);
                        next_cnt   = CNT_W'(WORD_W - 1);
                    end
                end
                H_DATA: begin
                    if (cnt != '0) begin
                        next_hdat = sr[SR_W-1];
                        next_sr   = {sr[SR_W-2:0], 1'b0};
                        next_cnt  = cnt - CNT_W'(1);
                    end else begin
                        next_state = H_WRITE;
                        next_mode  = swnvm_pkg::MODE_WRITE;
                        next_hoe   = 1'b0;
                        next_cnt   = CNT_W'(PROG_PERIODS - 1);
                    end
                end
                H_WRITE: begin
                    if (cnt != '0) begin
                        next_cnt = cnt - CNT_W'(1);
                    end else begin
                        next_state = H_IDLE;
                        next_mode  = swnvm_pkg::MODE_STANDBY;
                        next_ready = 1'b1;
                    end
                end
                H_READ: begin
                    next_state = H_SHIFT;
                    next_mode  = swnvm_pkg::MODE_SHIFT;
                    next_cnt   = CNT_W'(WORD_W - 1);
                end
                H_SHIFT: begin
                    if (cnt != '0) begin
                        next_cnt = cnt - CNT_W'(1);
                    end else begin
                        next_state = H_IDLE;
                        next_mode  = swnvm_pkg::MODE_STANDBY;
                        next_ready = 1'b1;
                        next_resp  = 1'b1;
                    end
                end
                default: begin
                    next_state = H_IDLE;
                    next_mode  = swnvm_pkg::MODE_STANDBY;
                    next_hoe   = 1'b0;
                    next_ready = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= H_IDLE;
            div_cnt <= '0;
            lclk <= 1'b0;
            mode <= swnvm_pkg::MODE_STANDBY;
            sr <= '0;
            cnt <= '0;
            op_write <= 1'b0;
            wdata <= '0;
            rdata <= '0;
            ready <= 1'b1;
            resp <= 1'b0;
            hoe <= 1'b0;
            hdat <= 1'b0;
        end else if (i_clock_en) begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            lclk <= next_lclk;
            mode <= next_mode;
            sr <= next_sr;
            cnt <= next_cnt;
            op_write <= next_op_write;
            wdata <= next_wdata;
            rdata <= next_rdata;
            ready <= next_ready;
            resp <= next_resp;
            hoe <= next_hoe;
            hdat <= next_hdat;
        end
    end

    assign link.link_clk      = lclk;
    assign link.mode_select_a = mode[2];
    assign link.mode_select_b = mode[1];
    assign link.mode_select_c = mode[0];
    assign link.host_oe       = hoe;
    assign link.host_data     = hdat;
    assign o_req_ready        = ready;
    assign o_resp_valid       = resp;
    assign o_resp_data        = rdata;
endmodule : swnvm_host

// *** tb/swnvm_assertions.sv ***
`timescale 1ns/1ps
module swnvm_assertions (
    input wire logic i_clock,       // System clock
    input wire logic i_reset_n,     // Async reset
    input wire logic link_clk,      // Link clock
    input wire logic mode_select_a, // Mode line a
    input wire logic mode_select_b, // Mode line b
    input wire logic mode_select_c, // Mode line c
    input wire logic host_data,     // Host drive value
    input wire logic host_oe,       // Host drive enable
    input wire logic dev_data,      // Device drive value
    input wire logic dev_oe,        // Device drive enable
    input wire logic data_line      // Resolved pin
);
    logic [2:0] mode;
    assign mode = {mode_select_a, mode_select_b, mode_select_c};

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    a_standby_floats: assert property (
        (mode == 3'h7 && $past(mode) == 3'h7 && $past(mode, 2) == 3'h7) |-> !dev_oe)
        else $error("pin driven in standby");
    a_reserved_floats: assert property (
        (mode == 3'h6 && $past(mode) == 3'h6 && $past(mode, 2) == 3'h6) |-> !dev_oe)
        else $error("pin driven on reserved code");
    a_entry_pin_input: assert property (
        (mode inside {3'h0, 3'h4} && $stable(mode) && $past(mode) == $past(mode, 2))
        |-> !dev_oe) else $error("pin driven during entry");
    a_idle_modes_float: assert property (
        (mode inside {3'h1, 3'h3, 3'h5} && $stable(mode) && $past(mode) == $past(mode, 2))
        |-> !dev_oe) else $error("pin driven in read, erase or write");
    a_shift_drives_pin: assert property (
        (mode == 3'h2 && $past(mode) == 3'h2 && $past(mode, 2) == 3'h2) |-> dev_oe)
        else $error("pin not driven in shift out");
    a_oe_rises_fast: assert property (
        (mode == 3'h2 && $past(mode) != 3'h2) |-> ##[0:2] dev_oe)
        else $error("output enable late");
    a_oe_released: assert property (
        (mode != 3'h2 && $past(mode) == 3'h2) |-> ##[0:2] !dev_oe)
        else $error("output enable not released");
    a_no_contention: assert property (
        !(dev_oe && host_oe)) else $error("both ends drive the pin");
    a_mode_moves_high: assert property (
        (mode != $past(mode)) |-> link_clk) else $error("mode changed with link clock low");
    a_host_data_high: assert property (
        (host_oe && $past(host_oe) && host_data != $past(host_data)) |-> link_clk)
        else $error("host data changed with link clock low");
    a_out_after_rise: assert property (
        (dev_oe && $past(dev_oe) && dev_data != $past(dev_data)) |-> link_clk)
        else $error("output bit changed with link clock low");
endmodule : swnvm_assertions

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        i_clock;
    logic        i_reset_n;
    logic        i_clock_en;
    logic        frz;
    logic        i_req_valid;
    logic        i_req_write;
    logic [5:0]  i_req_word;
    logic [13:0] i_req_data;
    logic        o_req_ready;
    logic        o_resp_valid;
    logic [13:0] o_resp_data;
    logic [13:0] o_data_word;
    logic [5:0]  o_word_index;
    logic        o_index_valid;
    logic [2:0]  o_mode;
    logic        o_prog_done;
    logic [13:0] model_mem [50];
    logic [13:0] cap;
    logic        link_q;
    int          n_errors;
    int          n_tests;
    int          n_addr;
    int          n_bits;
    int          n_done;
    int          seed;

    swnvm_if link_if ();
    swnvm_device #(.PROG_MIN_CYC(20)) swnvm_device_i (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_en(i_clock_en), .link(link_if),
        .o_data_word(o_data_word), .o_word_index(o_word_index),
        .o_index_valid(o_index_valid), .o_mode(o_mode), .o_prog_done(o_prog_done));
    swnvm_host #(.LINK_HALF_CYC(4), .PROG_PERIODS(8)) swnvm_host_i (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_en(i_clock_en), .link(link_if),
        .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_word(i_req_word),
        .i_req_data(i_req_data), .o_req_ready(o_req_ready), .o_resp_valid(o_resp_valid),
        .o_resp_data(o_resp_data));
    swnvm_assertions swnvm_assertions_i (
        .i_clock(i_clock), .i_reset_n(i_reset_n), .link_clk(link_if.link_clk),
        .mode_select_a(link_if.mode_select_a), .mode_select_b(link_if.mode_select_b),
        .mode_select_c(link_if.mode_select_c), .host_data(link_if.host_data),
        .host_oe(link_if.host_oe), .dev_data(link_if.dev_data), .dev_oe(link_if.dev_oe),
        .data_line(link_if.data_line));

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // Wire monitor: counts bits taken at each link fall
    always @(negedge i_clock) begin
        if (link_q && !link_if.link_clk) begin
            case ({link_if.mode_select_a, link_if.mode_select_b, link_if.mode_select_c})
                3'h4: n_addr++;
                3'h0, 3'h2: begin
                    n_bits++;
                    cap = {cap[12:0], link_if.data_line};
                end
                default: ;
            endcase
        end
        link_q = link_if.link_clk;
        if (o_prog_done === 1'b1) n_done++;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wait_ready();
        for (int k = 0; k < 20000; k++) begin
            @(negedge i_clock);
            if (o_req_ready === 1'b1) return;
        end
        check("ready wait", 0, 1);
        final_report();
    endtask : wait_ready

    task automatic do_op(logic wr, int word, logic [13:0] data);
        int k;
        wait_ready();
        @(posedge i_clock);
        i_req_valid <= 1'b1;
        i_req_write <= wr;
        i_req_word  <= word[5:0];
        i_req_data  <= data;
        @(posedge i_clock);
        i_req_valid <= 1'b0;
        n_addr = 0;
        n_bits = 0;
        n_done = 0;
        for (k = 0; k < 20000; k++) begin
            @(negedge i_clock);
            if (wr ? (o_req_ready === 1'b1) : (o_resp_valid === 1'b1)) break;
        end
        if (k == 20000) begin
            check("op wait", 0, 1);
            final_report();
        end else begin
            check("address bits", n_addr, 15);
            check("data bits", n_bits, 14);
            if (wr) begin
                model_mem[word] = data;
                check("wire data", cap, data);
                check("commits", n_done, 2);
                check("data register", o_data_word, data);
                check("last mode", o_mode, swnvm_pkg::MODE_WRITE);
            end else begin
                check("read data", o_resp_data, model_mem[word]);
                check("wire out", cap, model_mem[word]);
                check("read commits", n_done, 0);
                check("last mode", o_mode, swnvm_pkg::MODE_SHIFT);
            end
            check("word index", o_word_index, word);
            check("index valid", o_index_valid, 1);
        end
    endtask : do_op

    initial begin
        int wl [6];
        wl = '{0, 49, 9, 10, 25, 40};
        seed = 90;
        n_errors = 0;
        n_tests = 0;
        i_reset_n = 1'b0;
        i_clock_en = 1'b1;
        i_req_valid = 1'b0;
        i_req_write = 1'b0;
        i_req_word = 6'h00;
        i_req_data = 14'h0000;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'b1;
        wl[4] = $unsigned($random(seed)) % 50;
        foreach (wl[i]) do_op(1'b1, wl[i], 14'($random(seed)));
        foreach (wl[i]) do_op(1'b0, wl[i], 14'h0000);
        $display("test write_read done");
        do_op(1'b1, 0, 14'h0000);
        do_op(1'b1, 49, 14'h3FFF);
        do_op(1'b1, 49, 14'h2AAA);
        do_op(1'b0, 0, 14'h0000);
        do_op(1'b0, 49, 14'h0000);
        $display("test overwrite done");
        wait_ready();
        @(posedge i_clock);
        i_clock_en  <= 1'b0;
        i_req_valid <= 1'b1;
        i_req_write <= 1'b0;
        i_req_word  <= 6'h05;
        @(negedge i_clock);
        frz = link_if.link_clk;
        repeat (12) @(negedge i_clock);
        check("frozen link clock", link_if.link_clk, frz);
        check("frozen ready", o_req_ready, 1);
        @(posedge i_clock);
        i_clock_en  <= 1'b1;
        i_req_valid <= 1'b0;
        $display("test freeze done");
        wait_ready();
        @(posedge i_clock);
        i_req_valid <= 1'b1;
        i_req_write <= 1'b0;
        i_req_word  <= 6'(50 + $unsigned($random(seed)) % 14);
        repeat (3) begin
            @(negedge i_clock);
            check("ready on refused word", o_req_ready, 1);
        end
        @(posedge i_clock);
        i_req_valid <= 1'b0;
        $display("test refuse done");
        final_report();
    end
endmodule : testbench
